// file: include/iaef_params.svh
`ifndef IAEF_PARAMS_SVH
`define IAEF_PARAMS_SVH
`define IAEF_ADDR_COMM_EN 6'h02
`define IAEF_ADDR_AUX_EN 6'h03
`define IAEF_ADDR_COMM_FLAGS 6'h04
`define IAEF_ADDR_AUX_FLAGS 6'h05
`define IAEF_ADDR_ERROR 6'h06
`define IAEF_ADDR_STATUS 6'h07
`define IAEF_ADDR_COMMAND 6'h01
`define IAEF_ADDR_CONTROL 6'h0c
`define IAEF_RST_COMM_FLAGS 8'h14
`define IAEF_RST_AUX_FLAGS 8'h00
`define IAEF_RST_COMM_EN 8'h80
`define IAEF_RST_AUX_EN 8'h00
`define IAEF_RST_ERROR 8'h00
`define IAEF_RST_CONTROL 8'h00
`define IAEF_SEL_BIT 7
`define IAEF_AUX_MASK 8'h14
`define IAEF_ERR_MASK 8'hdf
`define IAEF_AUXEN_MASK 8'h94
`define IAEF_CMD_IDLE 4'h0
`define IAEF_CMD_CALC_CRC 4'h3
`define IAEF_CMD_TRANSMIT 4'h4
`define IAEF_CMD_RECEIVE 4'h8
`define IAEF_CMD_TRANSCEIVE 4'hc
`define IAEF_CMD_AUTHENT 4'he
`define IAEF_CMD_SOFT_RESET 4'hf
`define IAEF_CMD_MEM 4'h1
`define IAEF_CMD_RANDOM 4'h2
`define IAEF_CMD_NO_CHANGE 4'h7
`define IAEF_CTL_NEEDS_DATA 0
`define IAEF_CTL_CRC_EN 1
`define IAEF_CTL_RATE_106 2
`endif

// file: include/iaef_pkg.sv
package iaef_pkg;
  // Events reported by the surrounding datapaths, one cycle each.
  typedef struct packed {
    logic tx_last_bit_sent;
    logic rx_valid_end;
    logic cmd_self_done;
    logic timer_zero;
    logic crc_all_done;
    logic rx_start;
    logic collision;
    logic crc_fail;
    logic parity_fail;
    logic sof_bad;
    logic auth_count_bad;
    logic fifo_full_write;
    logic host_fifo_write;
    logic rf_turnaround;
  } iaef_events_t;

  typedef struct packed {
    logic fifo_high_level_status;
    logic fifo_low_level_status;
    logic fifo_not_empty;
    logic overheat;
    logic aux_serial_input_pin;
  } iaef_levels_t;
endpackage : iaef_pkg

// file: verilog/iaef_irq_flags.sv
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`include "iaef_params.svh"
module iaef_irq_flags (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [5:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire iaef_pkg::iaef_events_t ev,
  input wire iaef_pkg::iaef_levels_t lv,
  output logic [3:0] command_field,
  output logic antenna_off,
  output logic irq_out,
  output logic irq_oe_n
);
  // ******************************************************
  // Registers.
  // ******************************************************
  logic [7:0] comm_interrupt_flags;
  logic [7:0] aux_interrupt_flags;
  logic [7:0] error_flags;
  logic [7:0] comm_en;
  logic [7:0] aux_en;
  logic [7:0] control;
  logic aux_pin_q;
  logic irq_combined;
  logic cmd_known;
  logic cmd_start;
  logic [7:0] next_comm;
  logic [7:0] next_aux;
  logic [7:0] next_err;
  logic [7:0] comm_hw_set;
  logic [7:0] aux_hw_set;

  // Applies a masked set/clear write to a flag byte.
  function automatic logic [7:0] masked_write(input logic [7:0] cur,
                                              input logic [7:0] wv);
    if (wv[`IAEF_SEL_BIT]) begin
      masked_write = cur | {1'b0, wv[6:0]};
    end else begin
      masked_write = cur & ~{1'b0, wv[6:0]};
    end
  endfunction : masked_write

  function automatic logic is_known(input logic [3:0] c);
    is_known = (c == `IAEF_CMD_IDLE) || (c == `IAEF_CMD_MEM) ||
               (c == `IAEF_CMD_RANDOM) || (c == `IAEF_CMD_CALC_CRC) ||
               (c == `IAEF_CMD_TRANSMIT) || (c == `IAEF_CMD_NO_CHANGE) ||
               (c == `IAEF_CMD_RECEIVE) || (c == `IAEF_CMD_TRANSCEIVE) ||
               (c == `IAEF_CMD_AUTHENT) || (c == `IAEF_CMD_SOFT_RESET);
  endfunction : is_known

  assign cmd_start = wr && (addr == `IAEF_ADDR_COMMAND);
  assign cmd_known = is_known(wdata[3:0]);

  // ******************************************************
  // Command field.
  // ******************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      command_field <= `IAEF_CMD_IDLE;
    end else if (cmd_start) begin
      command_field <= cmd_known ? wdata[3:0] : `IAEF_CMD_IDLE;
    end else if (ev.cmd_self_done) begin
      command_field <= `IAEF_CMD_IDLE;
    end
  end

  // ******************************************************
  // Error register.
  // ******************************************************
  always_comb begin
    next_err = error_flags;
    if (cmd_start) begin
      next_err = error_flags & 8'h40;
    end
    if (ev.rx_start) begin
      next_err[3:0] = 4'h0;
    end
    if (ev.host_fifo_write &&
        (command_field == `IAEF_CMD_AUTHENT || ev.rf_turnaround)) begin
      next_err[7] = 1'b1;
    end
    if (lv.overheat) begin
      next_err[6] = 1'b1;
    end
    if (ev.fifo_full_write) begin
      next_err[4] = 1'b1;
    end
    if (ev.collision && control[`IAEF_CTL_RATE_106]) begin
      next_err[3] = 1'b1;
    end
    if (ev.crc_fail && control[`IAEF_CTL_CRC_EN]) begin
      next_err[2] = 1'b1;
    end
    if (ev.parity_fail && control[`IAEF_CTL_RATE_106]) begin
      next_err[1] = 1'b1;
    end
    if ((ev.sof_bad && control[`IAEF_CTL_RATE_106]) ||
        (ev.auth_count_bad && command_field == `IAEF_CMD_AUTHENT)) begin
      next_err[0] = 1'b1;
    end
    if (!control[`IAEF_CTL_RATE_106]) begin
      next_err[3] = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      error_flags <= `IAEF_RST_ERROR;
    end else begin
      error_flags <= next_err & `IAEF_ERR_MASK;
    end
  end

  assign antenna_off = error_flags[6];

  // ******************************************************
  // Request flags; hardware sets win over a host clear.
  // ******************************************************
  always_comb begin
    comm_hw_set = 8'h00;
    comm_hw_set[6] = ev.tx_last_bit_sent;
    comm_hw_set[5] = ev.rx_valid_end &&
      (!control[`IAEF_CTL_NEEDS_DATA] || lv.fifo_not_empty);
    comm_hw_set[4] = (ev.cmd_self_done && !cmd_start &&
                      command_field != `IAEF_CMD_IDLE) ||
                     (cmd_start && !cmd_known);
    comm_hw_set[3] = lv.fifo_high_level_status;
    comm_hw_set[2] = lv.fifo_low_level_status;
    comm_hw_set[1] = |error_flags;
    comm_hw_set[0] = ev.timer_zero;
    aux_hw_set = 8'h00;
    aux_hw_set[4] = lv.aux_serial_input_pin ^ aux_pin_q;
    aux_hw_set[2] = ev.crc_all_done &&
                    command_field == `IAEF_CMD_CALC_CRC;
    next_comm = comm_interrupt_flags;
    next_aux = aux_interrupt_flags;
    if (wr && addr == `IAEF_ADDR_COMM_FLAGS) begin
      next_comm = masked_write(comm_interrupt_flags, wdata);
    end
    if (wr && addr == `IAEF_ADDR_AUX_FLAGS) begin
      next_aux = masked_write(aux_interrupt_flags, wdata);
    end
    next_comm = (next_comm | comm_hw_set) & 8'h7f;
    next_aux = (next_aux | aux_hw_set) & `IAEF_AUX_MASK;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      comm_interrupt_flags <= `IAEF_RST_COMM_FLAGS;
      aux_interrupt_flags <= `IAEF_RST_AUX_FLAGS;
    end else begin
      comm_interrupt_flags <= next_comm;
      aux_interrupt_flags <= next_aux;
    end
  end

  // The edge reference follows the pin through reset, so a pin that idles
  // high does not look like an edge once reset is released.
  always_ff @(posedge mclk) begin
    aux_pin_q <= lv.aux_serial_input_pin;
  end

  // ******************************************************
  // Enables and control.
  // ******************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      comm_en <= `IAEF_RST_COMM_EN;
      aux_en <= `IAEF_RST_AUX_EN;
      control <= `IAEF_RST_CONTROL;
    end else if (wr) begin
      if (addr == `IAEF_ADDR_COMM_EN) begin
        comm_en <= wdata;
      end
      if (addr == `IAEF_ADDR_AUX_EN) begin
        aux_en <= wdata & `IAEF_AUXEN_MASK;
      end
      if (addr == `IAEF_ADDR_CONTROL) begin
        control <= wdata & 8'h07;
      end
    end
  end

  // ******************************************************
  // Interrupt pin.
  // ******************************************************
  assign irq_combined = |(comm_interrupt_flags[6:0] & comm_en[6:0]) ||
                        |(aux_interrupt_flags[4:0] & aux_en[4:0]);
  // Bit 7 of comm_en inverts, bit 7 of aux_en selects push-pull.
  assign irq_out = irq_combined ^ comm_en[7];
  assign irq_oe_n = aux_en[7] ? 1'b0 : irq_out;

  // ******************************************************
  // Read port.
  // ******************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      unique case (addr)
        `IAEF_ADDR_COMMAND: rdata <= {4'h0, command_field};
        `IAEF_ADDR_COMM_EN: rdata <= comm_en;
        `IAEF_ADDR_AUX_EN: rdata <= aux_en;
        `IAEF_ADDR_COMM_FLAGS: rdata <= comm_interrupt_flags;
        `IAEF_ADDR_AUX_FLAGS: rdata <= aux_interrupt_flags;
        `IAEF_ADDR_ERROR: rdata <= error_flags;
        `IAEF_ADDR_STATUS: rdata <= {3'h0, irq_combined, 2'h0,
                                      lv.fifo_high_level_status,
                                      lv.fifo_low_level_status};
        `IAEF_ADDR_CONTROL: rdata <= control;
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // ******************************************************
  // Checks.
  // ******************************************************
  property p_set_write;
    @(posedge mclk) disable iff (rst)
      wr && addr == `IAEF_ADDR_COMM_FLAGS && wdata[7] |=>
        (~comm_interrupt_flags & $past(wdata) & 8'h7f) == 8'h00;
  endproperty
  a_set_write: assert property (p_set_write)
    else $error("masked set write did not set flags");

  property p_aux_res;
    @(posedge mclk) disable iff (rst)
      (aux_interrupt_flags & 8'heb) == 8'h00;
  endproperty
  a_aux_res: assert property (p_aux_res)
    else $error("reserved aux bits not zero");

  property p_tx;
    @(posedge mclk) disable iff (rst)
      ev.tx_last_bit_sent |=> comm_interrupt_flags[6];
  endproperty
  a_tx: assert property (p_tx)
    else $error("transmit done flag not set");

  property p_err_flag;
    @(posedge mclk) disable iff (rst)
      |error_flags |=> comm_interrupt_flags[1];
  endproperty
  a_err_flag: assert property (p_err_flag)
    else $error("error flag not raised");

  property p_edge;
    @(posedge mclk) disable iff (rst)
      $changed(lv.aux_serial_input_pin) |=> aux_interrupt_flags[4];
  endproperty
  a_edge: assert property (p_edge)
    else $error("aux edge flag not raised");

  property p_temp;
    @(posedge mclk) disable iff (rst)
      lv.overheat |=> error_flags[6] && antenna_off;
  endproperty
  a_temp: assert property (p_temp)
    else $error("overtemperature not flagged");

  property p_cmd_clear;
    @(posedge mclk) disable iff (rst)
      cmd_start && !lv.overheat && !ev.fifo_full_write && !ev.host_fifo_write
      && !ev.collision && !ev.crc_fail && !ev.parity_fail && !ev.sof_bad
      && !ev.auth_count_bad |=> (error_flags & 8'hbf) == 8'h00;
  endproperty
  a_cmd_clear: assert property (p_cmd_clear)
    else $error("command start did not clear errors");

  property p_irq;
    @(posedge mclk) disable iff (rst)
      irq_out == ((|(comm_interrupt_flags[6:0] & comm_en[6:0]) ||
                   |(aux_interrupt_flags[4:0] & aux_en[4:0])) ^ comm_en[7]);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt pin wrong");

  property p_pp;
    @(posedge mclk) disable iff (rst)
      aux_en[7] |-> !irq_oe_n;
  endproperty
  a_pp: assert property (p_pp)
    else $error("push-pull pin not driven");

  property p_clear_write;
    @(posedge mclk) disable iff (rst)
      wr && addr == `IAEF_ADDR_COMM_FLAGS && !wdata[7] && comm_hw_set == 8'h00
      |=> (comm_interrupt_flags & $past(wdata) & 8'h7f) == 8'h00;
  endproperty
  a_clear_write: assert property (p_clear_write)
    else $error("masked clear write did not clear flags");

  property p_aux_set;
    @(posedge mclk) disable iff (rst)
      wr && addr == `IAEF_ADDR_AUX_FLAGS && wdata[7] |=>
        (~aux_interrupt_flags & $past(wdata) & `IAEF_AUX_MASK) == 8'h00;
  endproperty
  a_aux_set: assert property (p_aux_set)
    else $error("aux set write did not set flags");

  property p_no_drop;
    @(posedge mclk) disable iff (rst)
      !(wr && addr == `IAEF_ADDR_COMM_FLAGS) |=>
        (~comm_interrupt_flags & $past(comm_interrupt_flags)) == 8'h00;
  endproperty
  a_no_drop: assert property (p_no_drop)
    else $error("request flag dropped without a host clear");

  property p_rx;
    @(posedge mclk) disable iff (rst)
      ev.rx_valid_end && (!control[`IAEF_CTL_NEEDS_DATA] || lv.fifo_not_empty)
      |=> comm_interrupt_flags[5];
  endproperty
  a_rx: assert property (p_rx)
    else $error("receive done flag not set");

  property p_rx_empty;
    @(posedge mclk) disable iff (rst)
      ev.rx_valid_end && control[`IAEF_CTL_NEEDS_DATA] && !wr &&
      !lv.fifo_not_empty && !comm_interrupt_flags[5]
      |=> !comm_interrupt_flags[5];
  endproperty
  a_rx_empty: assert property (p_rx_empty)
    else $error("receive done flag set with an empty buffer");

  property p_unknown;
    @(posedge mclk) disable iff (rst)
      cmd_start && !cmd_known |=> command_field == `IAEF_CMD_IDLE &&
        comm_interrupt_flags[4];
  endproperty
  a_unknown: assert property (p_unknown)
    else $error("unknown command did not return to idle");

  property p_host_idle;
    @(posedge mclk) disable iff (rst)
      cmd_start && wdata[3:0] == `IAEF_CMD_IDLE && !comm_interrupt_flags[4]
      |=> !comm_interrupt_flags[4];
  endproperty
  a_host_idle: assert property (p_host_idle)
    else $error("host idle command raised the idle flag");

  property p_hi;
    @(posedge mclk) disable iff (rst)
      lv.fifo_high_level_status |=> comm_interrupt_flags[3];
  endproperty
  a_hi: assert property (p_hi)
    else $error("high level flag not latched");

  property p_lo;
    @(posedge mclk) disable iff (rst)
      lv.fifo_low_level_status |=> comm_interrupt_flags[2];
  endproperty
  a_lo: assert property (p_lo)
    else $error("low level flag not latched");

  property p_crc_done;
    @(posedge mclk) disable iff (rst)
      ev.crc_all_done && command_field == `IAEF_CMD_CALC_CRC
      |=> aux_interrupt_flags[2];
  endproperty
  a_crc_done: assert property (p_crc_done)
    else $error("checksum done flag not set");

  property p_wr_err;
    @(posedge mclk) disable iff (rst)
      ev.host_fifo_write && (command_field == `IAEF_CMD_AUTHENT ||
        ev.rf_turnaround) |=> error_flags[7];
  endproperty
  a_wr_err: assert property (p_wr_err)
    else $error("host write error not set");

  property p_rx_start;
    @(posedge mclk) disable iff (rst)
      ev.rx_start && !ev.collision && !ev.crc_fail && !ev.parity_fail &&
      !ev.sof_bad && !ev.auth_count_bad |=> error_flags[3:0] == 4'h0;
  endproperty
  a_rx_start: assert property (p_rx_start)
    else $error("receiver start did not clear errors");

  property p_od;
    @(posedge mclk) disable iff (rst)
      !aux_en[7] |-> irq_oe_n == irq_out;
  endproperty
  a_od: assert property (p_od)
    else $error("open drain pin driven while high");
endmodule : iaef_irq_flags

// file: sim/iaef_host_model.sv
`timescale 1ns/1ps
module iaef_host_model (
  output logic [5:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic mclk,
  input wire logic [7:0] rdata
);
  // ****************************************
  // Host register access
  // ****************************************
  initial begin
    addr = 6'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end

  task automatic reg_wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    @(negedge mclk);
  endtask : reg_wr

  task automatic reg_rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    d = rdata;
  endtask : reg_rd

  // The host alone clears every request flag.
  task automatic clr_flags();
    reg_wr(6'h04, 8'h7f);
    reg_wr(6'h05, 8'h14);
  endtask : clr_flags
endmodule : iaef_host_model

// file: sim/irq_and_error_flags_test.sv
`timescale 1ns/1ps
module irq_and_error_flags_test;
  // ****************************************
  // Harness
  // ****************************************
  logic mclk = 1'b0;
  logic rst;
  logic [5:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  iaef_pkg::iaef_events_t ev;
  iaef_pkg::iaef_levels_t lv;
  logic [3:0] command_field;
  logic antenna_off;
  logic irq_out;
  logic irq_oe_n;
  int miscompares = 0;
  int check_count = 0;
  logic [13:0] em [5] = '{14'h0004, 14'h0080, 14'h0040, 14'h0020, 14'h0010};
  logic [7:0] ex [5] = '{8'h10, 8'h08, 8'h04, 8'h02, 8'h01};
  logic [7:0] acc;
  // Bit n is high when command code n is a known command.
  logic [15:0] known_cmds = 16'hd19f;
  logic [3:0] want_cmd;

  always #4 mclk = ~mclk;

  iaef_irq_flags iaef_irq_flags_i (.mclk(mclk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ev(ev), .lv(lv),
    .command_field(command_field), .antenna_off(antenna_off),
    .irq_out(irq_out), .irq_oe_n(irq_oe_n));

  iaef_host_model host_i (.addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .mclk(mclk), .rdata(rdata));

  task automatic tally_and_finish();
    if (miscompares == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk_reg(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] got;
    host_i.reg_rd(a, got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected reg %h: expected %h seen %h", a, exp, got);
    end
  endtask : chk_reg

  task automatic chk_pin(input string n, input logic [3:0] exp,
                         input logic [3:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", n, exp, got);
    end
  endtask : chk_pin

  // Event mask bits: 13 tx end, 12 rx end, 11 self done, 10 timer,
  // 9 crc done, 8 rx start, 7 collision, 6 crc fail, 5 parity, 4 sof,
  // 3 auth count, 2 full write, 1 host fifo write, 0 turnaround.
  task automatic fire(input logic [13:0] m);
    @(posedge mclk);
    ev <= m;
    @(posedge mclk);
    ev <= '0;
  endtask : fire

  // Flags are read a few cycles late to show that they hold.
  task automatic ev_chk(input logic [13:0] m, input logic [5:0] a,
                        input logic [7:0] exp);
    host_i.clr_flags();
    fire(m);
    repeat (4) @(posedge mclk);
    chk_reg(a, exp);
  endtask : ev_chk

  task automatic lv_chk(input logic [4:0] l, input logic [4:0] keep,
                        input logic [5:0] a, input logic [7:0] exp);
    host_i.clr_flags();
    @(posedge mclk);
    lv <= l;
    @(posedge mclk);
    lv <= keep;
    chk_reg(a, exp);
  endtask : lv_chk

  initial begin
    #100000;
    miscompares++;
    tally_and_finish();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    rst = 1'b1;
    ev = '0;
    lv = '0;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    chk_reg(6'h04, 8'h14);
    chk_reg(6'h05, 8'h00);
    chk_reg(6'h06, 8'h00);
    chk_reg(6'h3f, 8'h00);
    chk_pin("irq_out", 4'h1, {3'h0, irq_out});
    chk_pin("irq_oe_n", 4'h1, {3'h0, irq_oe_n});
    host_i.reg_wr(6'h04, 8'h7f);
    chk_reg(6'h04, 8'h00);
    host_i.reg_wr(6'h04, 8'h81);
    host_i.reg_wr(6'h04, 8'hc0);
    chk_reg(6'h04, 8'h41);
    host_i.reg_wr(6'h04, 8'h40);
    chk_reg(6'h04, 8'h01);
    host_i.reg_wr(6'h05, 8'hff);
    chk_reg(6'h05, 8'h14);
    host_i.reg_wr(6'h05, 8'h04);
    chk_reg(6'h05, 8'h10);
    host_i.reg_wr(6'h02, 8'h01);
    chk_pin("irq_out", 4'h1, {3'h0, irq_out});
    chk_pin("irq_oe_n", 4'h1, {3'h0, irq_oe_n});
    chk_reg(6'h07, 8'h10);
    host_i.reg_wr(6'h02, 8'h81);
    chk_pin("irq_out", 4'h0, {3'h0, irq_out});
    chk_pin("irq_oe_n", 4'h0, {3'h0, irq_oe_n});
    host_i.reg_wr(6'h03, 8'h80);
    host_i.reg_wr(6'h02, 8'h01);
    chk_pin("irq_oe_n", 4'h0, {3'h0, irq_oe_n});
    host_i.reg_wr(6'h04, 8'h01);
    chk_pin("irq_out", 4'h0, {3'h0, irq_out});
    ev_chk(14'h2000, 6'h04, 8'h40);
    ev_chk(14'h1000, 6'h04, 8'h20);
    ev_chk(14'h0400, 6'h04, 8'h01);
    host_i.reg_wr(6'h0c, 8'h01);
    ev_chk(14'h1000, 6'h04, 8'h00);
    @(posedge mclk);
    lv <= 5'h04;
    ev_chk(14'h1000, 6'h04, 8'h20);
    host_i.reg_wr(6'h01, 8'h04);
    chk_pin("command_field", 4'h4, command_field);
    ev_chk(14'h0800, 6'h04, 8'h10);
    chk_pin("command_field", 4'h0, command_field);
    host_i.clr_flags();
    host_i.reg_wr(6'h01, 8'h05);
    chk_pin("command_field", 4'h0, command_field);
    chk_reg(6'h04, 8'h10);
    host_i.clr_flags();
    host_i.reg_wr(6'h01, 8'h00);
    chk_reg(6'h04, 8'h00);
    for (int i = 0; i < 16; i++) begin
      host_i.clr_flags();
      host_i.reg_wr(6'h01, 8'(i));
      want_cmd = known_cmds[i] ? 4'(i) : 4'h0;
      chk_pin("command_field", want_cmd, command_field);
      chk_reg(6'h04, known_cmds[i] ? 8'h00 : 8'h10);
    end
    lv_chk(5'h14, 5'h04, 6'h04, 8'h08);
    lv_chk(5'h0c, 5'h04, 6'h04, 8'h04);
    lv_chk(5'h05, 5'h05, 6'h05, 8'h10);
    lv_chk(5'h04, 5'h04, 6'h05, 8'h10);
    host_i.reg_wr(6'h01, 8'h03);
    ev_chk(14'h0200, 6'h05, 8'h04);
    host_i.reg_wr(6'h0c, 8'h06);
    host_i.reg_wr(6'h01, 8'h0e);
    ev_chk(14'h0002, 6'h06, 8'h80);
    fire(14'h0008);
    chk_reg(6'h06, 8'h81);
    chk_reg(6'h04, 8'h02);
    host_i.reg_wr(6'h01, 8'h03);
    chk_reg(6'h06, 8'h00);
    host_i.reg_wr(6'h06, 8'hff);
    chk_reg(6'h06, 8'h00);
    fire(14'h0002);
    chk_reg(6'h06, 8'h00);
    fire(14'h0003);
    acc = 8'h80;
    chk_reg(6'h06, acc);
    for (int i = 0; i < 5; i++) begin
      fire(em[i]);
      acc = acc | ex[i];
      chk_reg(6'h06, acc);
    end
    host_i.reg_wr(6'h0c, 8'h02);
    chk_reg(6'h06, 8'h97);
    fire(14'h0100);
    chk_reg(6'h06, 8'h90);
    host_i.reg_wr(6'h0c, 8'h02);
    fire(14'h00b0);
    chk_reg(6'h06, 8'h90);
    host_i.reg_wr(6'h0c, 8'h04);
    fire(14'h0040);
    chk_reg(6'h06, 8'h90);
    @(posedge mclk);
    lv <= 5'h06;
    @(posedge mclk);
    lv <= 5'h04;
    @(negedge mclk);
    chk_pin("antenna_off", 4'h1, {3'h0, antenna_off});
    chk_reg(6'h06, 8'hd0);
    host_i.reg_wr(6'h01, 8'h03);
    chk_reg(6'h06, 8'h40);
    tally_and_finish();
  end
endmodule : irq_and_error_flags_test
